// File: verilog/ilo_exec.sv
/*
 Decode and execute of the three indexed literal offset instructions,
 with a small data memory, accumulator, base pointer, bank select and
 status, all reached over AHB-Lite.
 Assumes a single AHB-Lite master; one core clock, synchronous reset.
*/
// Our own choices: the placing of the registers and the AHB-Lite register port.
// Functional notes
// - enabled: operand up to 5Fh offsets base
// - indexed only when enabled and a=0
// - disabled: access bank or bank select
// - indexed add: accumulator plus indexed byte
// - d=0: sum to accumulator only
// - d=1: sum written back to memory
// - bit set sets bit b of byte
// - fill writes FFh into indexed byte
// - enable defaults zero, disables extension
`timescale 1ns/10ps
`include "ilo_params.svh"

module ilo_exec (
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic BUSY_O
);

   typedef struct packed {
      ilo_pkg::phase_t phase;
      ilo_pkg::op_t op;
      logic [15:0] instr;
      logic [11:0] ea;
      logic [7:0] operand;
      logic [7:0] result;
      logic to_mem;
      logic [7:0] accum;
      logic [11:0] base;
      logic [3:0] bsr;
      logic xse;
      logic [4:0] status;
      logic [11:0] maddr;
      logic ap_valid;
      logic ap_write;
      logic [31:0] ap_addr;
      logic [31:0] rdata;
      logic ap_word;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [7:0] ram [0:`ILO_RAM_DEPTH-1];
   logic [7:0] ram_rd;
   logic ram_we;
   logic [11:0] ram_wa;
   logic [7:0] ram_wd;
   logic [7:0] alu_sum;
   logic [4:0] alu_flags;
   logic [7:0] bit_mask;

   // classify an instruction word
   function automatic ilo_pkg::op_t classify(input logic [15:0] w);
      ilo_pkg::op_t o;
      o = ilo_pkg::OP_NONE;
      // bit 8 is the access bit and stays free: it picks bank or indexed path
      if (w[15:10] == `ILO_OPC_ADD) begin
         o = ilo_pkg::OP_ADD;
      end else if (w[15:12] == `ILO_OPC_BSET) begin
         o = ilo_pkg::OP_BSET;
      end else if ({w[15:9], 1'b0} == `ILO_OPC_FILL) begin
         o = ilo_pkg::OP_FILL;
      end
      return o;
   endfunction

   // effective address of the 8-bit file operand, access bit a
   function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
      input logic xse, input logic [11:0] base, input logic [3:0] bsr);
      logic [11:0] ea;
      ea = 12'h000;
      if (xse && !a && f <= `ILO_INDEX_LIMIT) begin
         ea = base + {4'h0, f};
      end else if (a) begin
         ea = {bsr, f};
      end else if (f[7]) begin
         ea = {`ILO_ACCESS_HI, f};
      end else begin
         ea = {4'h0, f};
      end
      return ea;
   endfunction

   // register word as seen on the bus; narrow fields read zero above
   function automatic logic [31:0] reg_word(input logic [31:0] addr, input state_t s,
      input logic [7:0] mem_byte);
      logic [31:0] w;
      w = 32'h00000000;
      case (addr)
         `ILO_ADDR_ACCUM: w = {24'h000000, s.accum};
         `ILO_ADDR_BASE: w = {20'h00000, s.base};
         `ILO_ADDR_BSR: w = {28'h0000000, s.bsr};
         `ILO_ADDR_CFG: w = {31'h00000000, s.xse};
         `ILO_ADDR_STATUS: w = {27'h0000000, s.status};
         `ILO_ADDR_INSTR: w = {16'h0000, s.instr};
         `ILO_ADDR_MADDR: w = {20'h00000, s.maddr};
         `ILO_ADDR_MDATA: w = {24'h000000, mem_byte};
         default: w = 32'h00000000;
      endcase
      return w;
   endfunction

   ilo_alu alu_u (
      .a_i(st_reg.accum),
      .b_i(st_reg.operand),
      .sum_o(alu_sum),
      .flags_o(alu_flags)
   );

   assign ram_rd = ram[st_reg.ea];

   // one-hot mask of the bit-set position
   for (genvar i = 0; i < 8; i++) begin : g_mask
      assign bit_mask[i] = (st_reg.instr[11:9] == 3'(i));
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      ram_we = 1'b0;
      ram_wa = st_reg.ea;
      ram_wd = st_reg.result;

      // bus data phase
      if (st_reg.ap_valid) begin
         // only whole-word writes update a register
         if (st_reg.ap_write && st_reg.ap_word) begin
            case (st_reg.ap_addr)
               `ILO_ADDR_ACCUM: st_next.accum = HWDATA_I[7:0];
               `ILO_ADDR_BASE: st_next.base = HWDATA_I[11:0];
               `ILO_ADDR_BSR: st_next.bsr = HWDATA_I[3:0];
               `ILO_ADDR_CFG: st_next.xse = HWDATA_I[0];
               `ILO_ADDR_STATUS: st_next.status = HWDATA_I[4:0];
               `ILO_ADDR_INSTR: begin
                  // a new instruction only when idle
                  if (st_reg.phase == ilo_pkg::PH_DECODE && st_reg.op == ilo_pkg::OP_NONE) begin
                     st_next.instr = HWDATA_I[15:0];
                     st_next.op = classify(HWDATA_I[15:0]);
                  end
               end
               `ILO_ADDR_MADDR: st_next.maddr = HWDATA_I[11:0];
               `ILO_ADDR_MDATA: begin
                  ram_we = 1'b1;
                  ram_wa = st_reg.maddr;
                  ram_wd = HWDATA_I[7:0];
               end
               default: ;
            endcase
         end
      end

      // instruction sequencer
      // four phases, one cycle each
      case (st_reg.phase)
         ilo_pkg::PH_DECODE: begin
            if (st_reg.op != ilo_pkg::OP_NONE) begin
               st_next.ea = eff_addr(st_reg.instr[7:0], st_reg.instr[8], st_reg.xse,
                  st_reg.base, st_reg.bsr);
               st_next.phase = ilo_pkg::PH_READ;
            end
         end
         ilo_pkg::PH_READ: begin
            st_next.operand = ram_rd;
            st_next.phase = ilo_pkg::PH_PROCESS;
         end
         ilo_pkg::PH_PROCESS: begin
            st_next.to_mem = 1'b1;
            case (st_reg.op)
               ilo_pkg::OP_ADD: begin
                  st_next.result = alu_sum;
                  st_next.status = alu_flags;
                  st_next.to_mem = st_reg.instr[9];
               end
               ilo_pkg::OP_BSET: begin
                  st_next.result = st_reg.operand | bit_mask;
               end
               ilo_pkg::OP_FILL: begin
                  st_next.result = `ILO_FILL_VALUE;
               end
               default: st_next.to_mem = 1'b0;
            endcase
            st_next.phase = ilo_pkg::PH_WRITE;
         end
         ilo_pkg::PH_WRITE: begin
            if (st_reg.to_mem) begin
               ram_we = 1'b1;
               ram_wa = st_reg.ea;
               ram_wd = st_reg.result;
            end else begin
               st_next.accum = st_reg.result;
            end
            st_next.op = ilo_pkg::OP_NONE;
            st_next.phase = ilo_pkg::PH_DECODE;
         end
         default: st_next.phase = ilo_pkg::PH_DECODE;
      endcase

      // bus address phase, always zero wait
      st_next.ap_valid = HSEL_I && HREADY_I && HTRANS_I[1];
      st_next.ap_write = HWRITE_I;
      st_next.ap_addr = HADDR_I;
      st_next.ap_word = (HSIZE_I == `ILO_HSIZE_WORD);
      if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
         st_next.rdata = reg_word(HADDR_I, st_next, ram[st_reg.maddr]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I) begin
         st_reg <= '0;
         st_reg.phase <= ilo_pkg::PH_DECODE;
         st_reg.op <= ilo_pkg::OP_NONE;
         st_reg.accum <= `ILO_ACCUM_RESET;
         st_reg.base <= `ILO_BASE_RESET;
         st_reg.bsr <= `ILO_BSR_RESET;
         st_reg.xse <= `ILO_XSE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (ram_we) begin
         ram[ram_wa] <= ram_wd;
      end
   end

   assign HRDATA_O = st_reg.rdata;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign BUSY_O = (st_reg.op != ilo_pkg::OP_NONE);

endmodule // ilo_exec

// File: pkg/ilo_params.svh
/*
 Holds offsets, field positions, reset values and opcodes for the
 indexed literal offset executor. Assumes nothing of its surroundings.
*/
`ifndef ILO_PARAMS_SVH
`define ILO_PARAMS_SVH

`define ILO_INDEX_LIMIT 8'h5F
`define ILO_OPC_ADD 6'h09
`define ILO_OPC_BSET 4'h8
`define ILO_OPC_FILL 8'h68
`define ILO_FILL_VALUE 8'hFF
`define ILO_ACCUM_RESET 8'h00
`define ILO_BASE_RESET 12'h000
`define ILO_BSR_RESET 4'h0
`define ILO_XSE_RESET 1'b0
`define ILO_ACCESS_HI 4'hF
`define ILO_ADDR_ACCUM 32'h00
`define ILO_ADDR_BASE 32'h04
`define ILO_ADDR_BSR 32'h08
`define ILO_ADDR_CFG 32'h0C
`define ILO_ADDR_STATUS 32'h10
`define ILO_ADDR_INSTR 32'h14
`define ILO_ADDR_MADDR 32'h18
`define ILO_ADDR_MDATA 32'h1C
`define ILO_ST_C 0
`define ILO_ST_DC 1
`define ILO_ST_Z 2
`define ILO_ST_OV 3
`define ILO_ST_N 4
`define ILO_RAM_DEPTH 4096
`define ILO_HSIZE_WORD 3'h2

`endif

// File: pkg/ilo_pkg.sv
/*
 Types for the indexed literal offset executor.
 Assumes ilo_params.svh for the numbers.
*/
package ilo_pkg;

   typedef enum logic [1:0] {
      PH_DECODE = 2'b00,
      PH_READ = 2'b01,
      PH_PROCESS = 2'b11,
      PH_WRITE = 2'b10
   } phase_t;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_ADD = 2'b01,
      OP_BSET = 2'b10,
      OP_FILL = 2'b11
   } op_t;

   typedef struct packed {
      logic [7:0] n;
      logic [7:0] r;
      logic c;
      logic dc;
      logic ov;
   } sum_t;

endpackage

// File: verilog/ilo_alu.sv
/*
 Adder for the indexed add: sum and status flags.
 Assumes operands stable for the processing phase; purely combinational.
*/
`timescale 1ns/10ps
`include "ilo_params.svh"

module ilo_alu (
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   output logic [7:0] sum_o,
   output logic [4:0] flags_o
);

   logic [8:0] full;
   logic [4:0] low;

   always_comb begin
      full = {1'b0, a_i} + {1'b0, b_i};
      low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
      sum_o = full[7:0];
      flags_o = 5'h00;
      flags_o[`ILO_ST_C] = full[8];
      flags_o[`ILO_ST_DC] = low[4];
      flags_o[`ILO_ST_Z] = (full[7:0] == 8'h00);
      flags_o[`ILO_ST_OV] = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
      flags_o[`ILO_ST_N] = full[7];
   end

endmodule // ilo_alu

// File: verif/ilo_exec_monitor.sv
/*
 Port checker for ilo_exec.
 Assumes it is bound onto ilo_exec.
*/
`timescale 1ns/10ps
`include "ilo_params.svh"

module ilo_exec_monitor (
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic BUSY_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);
   logic rd_ap;
   assign rd_ap = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
   logic wr_ap;
   assign wr_ap = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
   ////////////////////////////////////////////////////////////////
   a_resp_okay: assert property (HRESP_O == 1'b0)
      else $error("response not okay");
   a_ready_high: assert property (HREADYOUT_O)
      else $error("wait state seen");
   a_busy_bounded: assert property ($rose(BUSY_O) |-> BUSY_O[*4] ##1 !BUSY_O)
      else $error("busy not four cycles");
   a_bset_launch: assert property ((wr_ap && HADDR_I == `ILO_ADDR_INSTR && !BUSY_O)
      ##1 (HWDATA_I[15:12] == `ILO_OPC_BSET) |=> BUSY_O) else $error("bit set not started");
   a_reset_quiet: assert property (disable iff (1'b0)
      !RST_B_I |=> !BUSY_O && HRDATA_O == 32'h0)
      else $error("outputs not cleared by reset");
   a_rdata_hold: assert property (!$past(rd_ap) |-> $stable(HRDATA_O))
      else $error("read data moved");
   a_cfg_narrow: assert property (rd_ap && HADDR_I == `ILO_ADDR_CFG
      |=> HRDATA_O[31:1] == 31'h0) else $error("config upper bits set");
   a_status_narrow: assert property (rd_ap && HADDR_I == `ILO_ADDR_STATUS
      |=> HRDATA_O[31:5] == 27'h0) else $error("status upper bits set");
   a_accum_narrow: assert property (rd_ap && HADDR_I == `ILO_ADDR_ACCUM
      |=> HRDATA_O[31:8] == 24'h0) else $error("accum upper bits set");
   c_busy: cover property ($rose(BUSY_O));
   c_status: cover property (rd_ap && HADDR_I == `ILO_ADDR_STATUS);
   c_accum: cover property (rd_ap && HADDR_I == `ILO_ADDR_ACCUM);
endmodule // ilo_exec_monitor

bind ilo_exec ilo_exec_monitor u_ilo_exec_monitor (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I),
   .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
   .HREADY_I(HREADY_I), .HWDATA_I(HWDATA_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
   .HRESP_O(HRESP_O), .BUSY_O(BUSY_O));

// File: verif/indexed_literal_offset_exec_bench.sv
/*
 Bench for ilo_exec: bus tasks, one task per scenario.
 Assumes ilo_exec and its monitor are compiled first.
*/
`timescale 1ns/10ps
`include "ilo_params.svh"

module indexed_literal_offset_exec_bench;
   logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwr = 1'b0, busy, rdy, resp;
   logic [1:0] htr = 2'h0;
   logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, rv;
   int miscompares = 0, num_checks = 0;
   always #2 clk = ~clk;
   ilo_exec u_ilo_exec (.CLK_SYS_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(ha),
      .HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(rdy),
      .HRDATA_O(hrd), .HREADYOUT_O(rdy), .HRESP_O(resp), .BUSY_O(busy));
   ////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic hold(input logic s, input int lim);
      int n;
      n = 0;
      @(posedge clk);
      while (s == 1'b1 ? rdy !== 1'b1 : busy !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n >= lim) begin
            miscompares++;
            results;
         end
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      ha <= a;
      hwr <= w;
      htr <= 2'h2;
      hold(1'b1, 50);
      htr <= 2'h0;
      hsel <= 1'b0;
      hwd <= d;
      hold(1'b1, 50);
      rv = hrd;
   endtask
   task automatic run(input logic [15:0] w);
      bus(1'b1, `ILO_ADDR_INSTR, {16'h0, w});
      hold(1'b0, 20);
   endtask
   task automatic mem(input logic w, input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, `ILO_ADDR_MADDR, {20'h0, a});
      bus(w, `ILO_ADDR_MDATA, {24'h0, d});
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 32'(i * 4), 32'h0);
         chk(rv, 32'h0); // cleared
      end
      bus(1'b0, 32'h40, 32'h0);
      chk(rv, 32'h0); // unmapped
   endtask
   task automatic t_off;
      mem(1'b1, 12'hA2C, 8'h00);
      mem(1'b1, 12'h02C, 8'h00);
      bus(1'b1, `ILO_ADDR_BASE, 32'h0A00);
      run(16'h682C);
      mem(1'b0, 12'hA2C, 8'h00);
      chk(rv, 32'h0); // not indexed
      mem(1'b0, 12'h02C, 8'h00);
      chk(rv, 32'hFF); // literal location
   endtask
   task automatic t_add;
      bus(1'b1, `ILO_ADDR_CFG, 32'h1); // enable set
      bus(1'b1, `ILO_ADDR_ACCUM, 32'h17);
      mem(1'b1, 12'hA2C, 8'h20);
      run(16'h242C);
      bus(1'b0, `ILO_ADDR_ACCUM, 32'h0);
      chk(rv, 32'h37); // sum
      mem(1'b0, 12'hA2C, 8'h00);
      chk(rv, 32'h20); // memory kept
      bus(1'b1, `ILO_ADDR_ACCUM, 32'h80);
      mem(1'b1, 12'hA10, 8'h80);
      run(16'h2610);
      mem(1'b0, 12'hA10, 8'h00);
      chk(rv, 32'h0); // written back
      bus(1'b0, `ILO_ADDR_ACCUM, 32'h0);
      chk(rv, 32'h80); // accum kept
      bus(1'b0, `ILO_ADDR_STATUS, 32'h0);
      chk(rv, 32'h0D); // c z ov
   endtask
   task automatic t_bset;
      mem(1'b1, 12'hA0A, 8'h00);
      for (int b = 0; b < 8; b++) begin
         run({4'h8, 3'(b), 9'h00A});
         mem(1'b0, 12'hA0A, 8'h00);
         chk(rv, 32'((16'h1 << (b + 1)) - 1)); // bit set
      end
      bus(1'b0, `ILO_ADDR_STATUS, 32'h0);
      chk(rv, 32'h0D); // flags kept
   endtask
   task automatic t_fill;
      run(16'h685F);
      mem(1'b0, 12'hA5F, 8'h00);
      chk(rv, 32'hFF); // top offset
      mem(1'b1, 12'h060, 8'h00);
      mem(1'b1, 12'hA60, 8'h00);
      run(16'h6860);
      mem(1'b0, 12'h060, 8'h00);
      chk(rv, 32'hFF); // literal
      mem(1'b0, 12'hA60, 8'h00);
      chk(rv, 32'h0); // not indexed
      bus(1'b0, `ILO_ADDR_STATUS, 32'h0);
      chk(rv, 32'h0D); // flags kept
   endtask
   task automatic t_bank;
      bus(1'b1, `ILO_ADDR_BSR, 32'h3);
      bus(1'b1, `ILO_ADDR_ACCUM, 32'h2);
      mem(1'b1, 12'h310, 8'h01);
      run(16'h2510);
      bus(1'b0, `ILO_ADDR_ACCUM, 32'h0);
      chk(rv, 32'h03); // bank operand
      bus(1'b0, `ILO_ADDR_STATUS, 32'h0);
      chk(rv, 32'h0); // flags cleared
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_off;
      t_add;
      t_bset;
      t_fill;
      t_bank;
      results;
   end
endmodule // indexed_literal_offset_exec_bench
